// ===== sfc_pkg.sv
// Package for the system flags control block: field positions, reset values, carriers
package sfc_pkg;
   // ****************************************
   // Flag positions
   // ****************************************
   localparam int SFC_FLAGS_W = 64;
   localparam int SFC_BIT_ONE = 1;
   localparam int SFC_TRAP_BIT = 8;
   localparam int SFC_INTEN_BIT = 9;
   localparam int SFC_IO_PRIVILEGE_FIELD_LO = 12;
   localparam int SFC_IO_PRIVILEGE_FIELD_HI = 13;
   localparam int SFC_NEST_BIT = 14;
   localparam int SFC_RESUME_BIT = 16;
   localparam int SFC_V86_BIT = 17;
   localparam int SFC_ALIGN_BIT = 18;
   localparam int SFC_VINT_BIT = 19;
   localparam int SFC_VPEND_BIT = 20;
   localparam int SFC_IDCAP_BIT = 21;
   // Bits this block owns, and the arithmetic status bits it passes through
   localparam logic [63:0] SFC_SYS_MASK = 64'h0000_0000_003F_7300;
   localparam logic [63:0] SFC_ARITH_MASK = 64'h0000_0000_0000_0CD5;
   localparam logic [63:0] SFC_RESET_VAL = 64'h0000_0000_0000_0002;
   localparam logic [1:0] SFC_USER_PL = 2'h3;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic start;         // Instruction begins
      logic retire;        // Instruction completed successfully
      logic isIret;        // Retiring instruction is an interrupt return
      logic isPopf;        // Retiring instruction is a pop-flags
      logic isFlagWrite;   // Other software write of the flags image
      logic isGateJump;    // Jump, call or soft interrupt through a task gate
      logic isCli;         // Clear-interrupt instruction
      logic isSti;         // Set-interrupt instruction
      logic isIo;          // I/O space instruction
      logic memAccess;     // Memory operand access
      logic unaligned;     // That access is unaligned
      logic [63:0] wrData; // Flags image loaded by the write
   } sfc_instr_t;

   typedef struct packed {
      logic taken;         // Exception or interrupt is being taken
      logic isBreakpoint;  // Debug exception from an instruction breakpoint
      logic isStringIntr;  // String instruction interrupted
      logic viaTaskGate;   // Delivery is a task switch through a gate
      logic [63:0] taskFlags; // Flags loaded by any task switch
      logic taskSwitch;    // A task switch loads new flags
   } sfc_event_t;

   typedef struct packed {
      logic [1:0] privLevel;
      logic v86ExtEn;
      logic pviEn;
      logic alignMaskEn;
      logic longMode;
   } sfc_ctrl_t;

   typedef struct packed {
      logic debugExc;
      logic gpExc;
      logic alignExc;
      logic takeMaskable;
      logic nestedReturn;
      logic breakSuppress;
   } sfc_fault_t;
endpackage : sfc_pkg

// ===== sfc_priv_check.sv
// Privilege decisions for I/O access and interrupt-enable updates
`timescale 1ns/10ps
module sfc_priv_check
   import sfc_pkg::*;
(
   input wire logic [1:0] privLevel,
   input wire logic [1:0] ioPrivField,
   input wire logic v86Mode,
   input wire logic v86ExtEn,
   input wire logic pviEn,
   input wire logic longMode,
   output logic ioAllowed,
   output logic ifWritable,
   output logic virtualActive
);
   always_comb begin
      ioAllowed = (privLevel <= ioPrivField);
      // Virtual flags only when extensions are on and field below 3
      virtualActive = ((v86Mode ? v86ExtEn : pviEn) && !longMode
                       || longMode && pviEn)
                      && (ioPrivField < SFC_USER_PL);
      ifWritable = v86Mode ? (ioPrivField == SFC_USER_PL)
                           : (privLevel <= ioPrivField);
   end
endmodule : sfc_priv_check

// ===== sfc_stack_image.sv
// Flags image pushed to the interrupt stack on exception entry
`timescale 1ns/10ps
module sfc_stack_image
   import sfc_pkg::*;
(
   input wire logic [63:0] flags,
   input wire logic isBreakpoint,
   output logic [63:0] image
);
   always_comb begin
      image = flags;
      image[SFC_RESUME_BIT] = !isBreakpoint;
   end
endmodule : sfc_stack_image

// ===== sfc_system_flags.sv
// System flags register with trap, interrupt, privilege and resume control
`timescale 1ns/10ps
// Summary of operation
// - Trap flag at start gives debug after instruction
// - Any exception or interrupt clears trap flag
// - Interrupt enable gates maskable interrupts only
// - NMI, soft interrupts, exceptions ignore enable
// - Enable writability from privilege, field, extensions
// - I/O needs privilege at most field
// - Task gate call or event sets nested flag
// - Legacy return with nested flag switches task
// - Resume flag suppresses instruction breakpoints
// - Resume cleared after next successful instruction other than a gate jump
// - Stacked image resume one, breakpoint zero
// - Mode flag changes only by switch/return
// - Unaligned user access with checks faults
// - Virtual flag replaces enable when active
// - Long mode virtual flags need PROTECTED_VIRTUAL_INTERRUPTS enable
// - Enabling with pending flag in virtual-8086 mode raises protection fault
// - Identification bit is software writable
// - Reserved read zero, bit one reads one
module sfc_system_flags
   import sfc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire sfc_instr_t instr,
   input wire sfc_event_t evt,
   input wire sfc_ctrl_t ctrl,
   input wire logic maskableReq,
   input wire logic nonMaskableReq,
   output logic [63:0] processorFlags,
   output logic [63:0] stackImage,
   output sfc_fault_t fault
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [63:0] flags;
      logic trapArmed;
      sfc_fault_t fault;
   } sfc_state_t;

   sfc_state_t state_q;
   sfc_state_t state_d;
   logic ioAllowed;
   logic ifWritable;
   logic virtualActive;
   logic [63:0] pushImage;

   function automatic logic [63:0] sfc_clean(input logic [63:0] v);
      sfc_clean = (v & (SFC_SYS_MASK | SFC_ARITH_MASK)) | SFC_RESET_VAL;
   endfunction : sfc_clean

   sfc_priv_check privCheck (
      .privLevel(ctrl.privLevel),
      .ioPrivField(state_q.flags[SFC_IO_PRIVILEGE_FIELD_HI:SFC_IO_PRIVILEGE_FIELD_LO]),
      .v86Mode(state_q.flags[SFC_V86_BIT]),
      .v86ExtEn(ctrl.v86ExtEn),
      .pviEn(ctrl.pviEn),
      .longMode(ctrl.longMode),
      .ioAllowed(ioAllowed),
      .ifWritable(ifWritable),
      .virtualActive(virtualActive)
   );

   sfc_stack_image stackImg (
      .flags(state_q.flags),
      .isBreakpoint(evt.isBreakpoint),
      .image(pushImage)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [63:0] w;
      logic [63:0] keep;
      w = '0;
      keep = '0;
      state_d = state_q;
      state_d.fault = '0;
      // Trap armed at instruction start, fires on completion
      if (instr.start) begin
         state_d.trapArmed = state_q.flags[SFC_TRAP_BIT];
      end
      if (instr.retire && state_q.trapArmed) begin
         state_d.fault.debugExc = 1'b1;
         state_d.trapArmed = 1'b0;
      end
      if (instr.retire) begin
         // A gate jump keeps resume so the instruction after it still restarts
         if (!instr.isGateJump) begin
            state_d.flags[SFC_RESUME_BIT] = 1'b0;
         end
         if (instr.isIo && !ioAllowed) begin
            state_d.fault.gpExc = 1'b1;
         end
         if (instr.memAccess && instr.unaligned && state_q.flags[SFC_ALIGN_BIT]
             && ctrl.alignMaskEn && ctrl.privLevel == SFC_USER_PL) begin
            state_d.fault.alignExc = 1'b1;
         end
         if (instr.isSti && virtualActive && state_q.flags[SFC_VPEND_BIT]
             && state_q.flags[SFC_V86_BIT]) begin
            state_d.fault.gpExc = 1'b1;
         end else if ((instr.isSti || instr.isCli) && virtualActive) begin
            state_d.flags[SFC_VINT_BIT] = instr.isSti;
         end else if ((instr.isSti || instr.isCli) && ifWritable) begin
            state_d.flags[SFC_INTEN_BIT] = instr.isSti;
         end else if (instr.isSti || instr.isCli) begin
            state_d.fault.gpExc = 1'b1;
         end
         if (instr.isIret && !ctrl.longMode && state_q.flags[SFC_NEST_BIT]) begin
            state_d.fault.nestedReturn = 1'b1;
         end else if (instr.isIret || instr.isPopf || instr.isFlagWrite) begin
            w = sfc_clean(instr.wrData);
            keep = '0;
            keep[SFC_V86_BIT] = !instr.isIret;
            if (!ifWritable) begin
               keep[SFC_INTEN_BIT] = 1'b1;
            end
            if (!(ctrl.privLevel == 2'h0)) begin
               keep[SFC_IO_PRIVILEGE_FIELD_HI] = 1'b1;
               keep[SFC_IO_PRIVILEGE_FIELD_LO] = 1'b1;
            end
            // Identification bit stays writable
            // A return that sets resume lands after the clear above
            state_d.flags = (w & ~keep) | (state_q.flags & keep);
         end
      end
      if (evt.taskSwitch) begin
         state_d.flags = sfc_clean(evt.taskFlags);
      end
      // Exception or interrupt entry
      if (evt.taken) begin
         state_d.flags[SFC_TRAP_BIT] = 1'b0;
         state_d.trapArmed = 1'b0;
         if (evt.viaTaskGate) begin
            state_d.flags[SFC_NEST_BIT] = 1'b1;
         end
      end
      if (instr.retire && instr.isGateJump && evt.viaTaskGate) begin
         state_d.flags[SFC_NEST_BIT] = 1'b1;
      end
      state_d.fault.takeMaskable = maskableReq && state_q.flags[SFC_INTEN_BIT];
      state_d.fault.breakSuppress = state_q.flags[SFC_RESUME_BIT];
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= '{flags: SFC_RESET_VAL, default: '0};
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // A non-maskable request suppresses takeMaskable at the output
   assign processorFlags = state_q.flags;
   assign stackImage = pushImage;
   always_comb begin
      fault = state_q.fault;
      fault.takeMaskable = state_q.fault.takeMaskable && !nonMaskableReq;
   end
endmodule : sfc_system_flags

// ===== sfc_system_flags_checker.sv
// Port checker for the system flags control block
`timescale 1ns/10ps
module sfc_system_flags_checker
   import sfc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire sfc_instr_t instr,
   input wire sfc_event_t evt,
   input wire sfc_ctrl_t ctrl,
   input wire logic maskableReq,
   input wire logic nonMaskableReq,
   input wire logic [63:0] processorFlags,
   input wire logic [63:0] stackImage,
   input wire sfc_fault_t fault
);
   // ****
   // Flag relations
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire logic [63:0] pf = processorFlags;
   a_trap_debug:
      assert property (instr.start && pf[8] && !evt.taken ##1 instr.retire && !evt.taken
         |=> fault.debugExc) else $error("no single step trap");
   a_trap_clear:
      assert property (evt.taken && !evt.taskSwitch |=> !pf[8]) else $error("trap kept");
   a_mask_gate:
      assert property (!pf[9] |=> !fault.takeMaskable) else $error("masked taken");
   a_io_check:
      assert property (instr.retire && instr.isIo && !evt.taken && !pf[17]
         && ctrl.privLevel > pf[13:12] |=> fault.gpExc) else $error("io not refused");
   a_align_trap:
      assert property (instr.retire && instr.memAccess && instr.unaligned && pf[18]
         && ctrl.alignMaskEn && ctrl.privLevel == 2'h3 |=> fault.alignExc)
         else $error("no align fault");
   a_nest_set:
      assert property (evt.taken && evt.viaTaskGate |=> pf[14]) else $error("nest not set");
   a_nest_ret:
      assert property (instr.retire && instr.isIret && !ctrl.longMode && pf[14]
         && !evt.taken |=> fault.nestedReturn) else $error("no nested return");
   a_resume_img:
      assert property (stackImage[16] == !evt.isBreakpoint) else $error("bad stack image");
   a_bit_one:
      assert property (pf[1] && pf[63:22] == 42'h0 && !pf[15] && !pf[5] && !pf[3])
         else $error("reserved bits wrong");
   a_popf_mode:
      assert property (instr.retire && instr.isPopf && !evt.taken && !evt.taskSwitch
         |=> $stable(pf[17])) else $error("popf moved mode");
   a_break_hold:
      assert property (pf[16] |=> fault.breakSuppress) else $error("breakpoint not held");
endmodule : sfc_system_flags_checker

bind sfc_system_flags sfc_system_flags_checker chk (.ref_clk, .reset, .instr, .evt, .ctrl,
   .maskableReq, .nonMaskableReq, .processorFlags, .stackImage, .fault);

// ===== sfc_system_flags_tb.sv
// Self-checking bench for the system flags control block
`timescale 1ns/10ps
module sfc_system_flags_tb
   import sfc_pkg::*;
;
   // ****
   // Stimulus and checks
   // ****
   typedef struct packed {
      logic [63:0] w;
      logic [1:0] pl;
      logic am;
      logic io;
      logic gp;
      logic ac;
   } sfc_row_t;
   // Image, level, mask enable, io or memory, expected faults
   localparam sfc_row_t ROWS [9] = '{
      '{64'h2, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0}, '{64'h2, 2'h1, 1'h0, 1'h1, 1'h1, 1'h0},
      '{64'h2002, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0}, '{64'h2002, 2'h3, 1'h0, 1'h1, 1'h1, 1'h0},
      '{64'h3002, 2'h3, 1'h0, 1'h1, 1'h0, 1'h0}, '{64'h40002, 2'h3, 1'h1, 1'h0, 1'h0, 1'h1},
      '{64'h40002, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0}, '{64'h40002, 2'h2, 1'h1, 1'h0, 1'h0, 1'h0},
      '{64'h2, 2'h3, 1'h1, 1'h0, 1'h0, 1'h0}};
   localparam sfc_instr_t IO_OP = '{retire: 1'h1, isIo: 1'h1, default: '0};
   localparam sfc_instr_t MEM_OP = '{retire: 1'h1, memAccess: 1'h1, unaligned: 1'h1, default: '0};
   localparam sfc_instr_t STI_OP = '{retire: 1'h1, isSti: 1'h1, default: '0};
   localparam sfc_instr_t CLI_OP = '{retire: 1'h1, isCli: 1'h1, default: '0};
   localparam sfc_instr_t GATE_OP = '{retire: 1'h1, isGateJump: 1'h1, default: '0};
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   sfc_instr_t instr = '0;
   sfc_event_t evt = '0;
   sfc_ctrl_t ctrl = '0;
   logic maskableReq = 1'h0;
   logic nonMaskableReq = 1'h0;
   logic [63:0] processorFlags;
   logic [63:0] stackImage;
   sfc_fault_t fault;
   int miscompares = 0;
   int totalChecks = 0;
   always #50 ref_clk = ~ref_clk;
   sfc_system_flags dut (.ref_clk, .reset, .instr, .evt, .ctrl, .maskableReq, .nonMaskableReq,
      .processorFlags, .stackImage, .fault);
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Held one cycle; the caller checks right after, before the next edge
   task automatic op(input sfc_instr_t i, input sfc_event_t e, input logic [1:0] pl);
      instr = i;
      evt = e;
      ctrl.privLevel = pl;
      @(negedge ref_clk);
   endtask : op
   task automatic idle(input int n);
      instr = '0;
      evt = '0;
      repeat (n) @(negedge ref_clk);
   endtask : idle
   function automatic sfc_instr_t load(input logic interrupt_return, input logic [63:0] w);
      return '{retire: 1'h1, isIret: interrupt_return, isPopf: !interrupt_return, wrData: w, default: '0};
   endfunction : load
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2000) @(posedge ref_clk);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (4) @(negedge ref_clk);
      reset = 1'h0;
      chk("reset flags", processorFlags, SFC_RESET_VAL);
      foreach (ROWS[k]) begin
         ctrl.alignMaskEn = ROWS[k].am;
         op(load(1'h0, ROWS[k].w), '0, 2'h0);
         op(ROWS[k].io ? IO_OP : MEM_OP, '0, ROWS[k].pl);
         chk("io fault", fault.gpExc, ROWS[k].gp);
         chk("align fault", fault.alignExc, ROWS[k].ac);
      end
      $display("rows done");
      // Mode bit set in the image must not land through a pop
      op(load(1'h0, 64'hFFFF_FFFF_FFE6_FEFF), '0, 2'h0);
      chk("popf image", processorFlags, 64'h247ED7);
      maskableReq = 1'h1;
      idle(1);
      chk("maskable on", fault.takeMaskable, 1'h1);
      op(load(1'h0, 64'h2), '0, 2'h0);
      idle(1);
      chk("maskable off", fault.takeMaskable, 1'h0);
      maskableReq = 1'h0;
      $display("masking done");
      op(load(1'h0, 64'h102), '0, 2'h0);
      op('{start: 1'h1, default: '0}, '0, 2'h0);
      op('{retire: 1'h1, default: '0}, '0, 2'h0);
      chk("single step", fault.debugExc, 1'h1);
      op('0, '{taken: 1'h1, default: '0}, 2'h0);
      chk("trap cleared", processorFlags[8], 1'h0);
      chk("stack image", stackImage, 64'h10002);
      op('0, '{taken: 1'h1, isBreakpoint: 1'h1, default: '0}, 2'h0);
      chk("bp image", stackImage, 64'h2);
      $display("trap done");
      op(load(1'h1, 64'h30002), '0, 2'h0);
      chk("interrupt_return load", processorFlags, 64'h30002);
      idle(1);
      chk("bp suppress", fault.breakSuppress, 1'h1);
      op('{retire: 1'h1, default: '0}, '0, 2'h0);
      chk("resume clear", processorFlags[16], 1'h0);
      op('0, '{taken: 1'h1, viaTaskGate: 1'h1, taskSwitch: 1'h1, taskFlags: 64'h2,
         default: '0}, 2'h0);
      chk("nested set", processorFlags, 64'h4002);
      op(load(1'h1, 64'h2), '0, 2'h0);
      chk("nested return", fault.nestedReturn, 1'h1);
      $display("resume and nesting done");
      // Rights for the enable bit outside virtual mode
      op(load(1'h0, 64'h2), '0, 2'h0);
      op(STI_OP, '0, 2'h0);
      chk("sti level 0", processorFlags, 64'h202);
      op(CLI_OP, '0, 2'h3);
      chk("cli refused", fault.gpExc, 1'h1);
      chk("cli kept", processorFlags, 64'h202);
      maskableReq = 1'h1;
      nonMaskableReq = 1'h1;
      idle(1);
      chk("nmi first", fault.takeMaskable, 1'h0);
      nonMaskableReq = 1'h0;
      idle(1);
      chk("maskable back", fault.takeMaskable, 1'h1);
      maskableReq = 1'h0;
      $display("enable rights done");
      // Protected-mode virtual flag, then long mode needing the enable
      ctrl.pviEn = 1'h1;
      op(STI_OP, '0, 2'h3);
      chk("virtual sti", processorFlags, 64'h80202);
      ctrl.pviEn = 1'h0;
      ctrl.longMode = 1'h1;
      op(CLI_OP, '0, 2'h3);
      chk("long no pvi", fault.gpExc, 1'h1);
      ctrl.pviEn = 1'h1;
      op(CLI_OP, '0, 2'h3);
      chk("long pvi cli", processorFlags, 64'h202);
      ctrl.longMode = 1'h0;
      ctrl.pviEn = 1'h0;
      // Extensions on before the pending flag is relied upon
      ctrl.v86ExtEn = 1'h1;
      op(load(1'h1, 64'h120002), '0, 2'h0);
      chk("enter v86", processorFlags, 64'h120002);
      op(STI_OP, '0, 2'h3);
      chk("pending sti", fault.gpExc, 1'h1);
      chk("pending kept", processorFlags, 64'h120002);
      op(load(1'h1, 64'h10002), '0, 2'h0);
      chk("resume set", processorFlags, 64'h10002);
      op(GATE_OP, '0, 2'h0);
      chk("gate keeps resume", processorFlags[16], 1'h1);
      op('{retire: 1'h1, default: '0}, '0, 2'h0);
      chk("gate then clear", processorFlags[16], 1'h0);
      ctrl.v86ExtEn = 1'h0;
      $display("virtual flags done");
      reset = 1'h1;
      idle(2);
      chk("mid reset flags", processorFlags, SFC_RESET_VAL);
      chk("mid reset faults", fault, '0);
      reset = 1'h0;
      idle(2);
      $display("reset done");
      wrap_up();
   end
endmodule : sfc_system_flags_tb
